/* common/lbam_pkg.sv */
// package: constants for the leaky bucket activity monitor
package lbam_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned CYCLE_MS = 128;
    localparam int unsigned CYCLE_CLKS = CLK_HZ / 1000 * CYCLE_MS;
    localparam logic [7:0] CLEAR_LIMIT_RESET = 8'h04;
    localparam logic [7:0] MAX_FILL_RESET = 8'h08;
    localparam logic [7:0] RAISE_LIMIT_RESET = 8'h06;
    localparam logic [1:0] DECAY_RATE_RESET = 2'h1;
    localparam logic [1:0] DECAY_EVERY_1 = 2'h0;
    localparam logic [1:0] DECAY_EVERY_2 = 2'h1;
    localparam logic [1:0] DECAY_EVERY_4 = 2'h2;
    localparam logic [1:0] DECAY_EVERY_8 = 2'h3;
    localparam logic [2:0] RUN_1 = 3'h0;
    localparam logic [2:0] RUN_2 = 3'h1;
    localparam logic [2:0] RUN_4 = 3'h3;
    localparam logic [2:0] RUN_8 = 3'h7;
endpackage

/* core/lbam_monitor.sv */
// leaky bucket accumulator scoring one reference input's faults
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////
module lbam_monitor #(
    parameter int unsigned CYCLE_CLKS = lbam_pkg::CYCLE_CLKS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // monitored input status, level
    input wire logic input_fault,
    // register write port
    input wire logic clear_limit_we,
    input wire logic max_fill_we,
    input wire logic [7:0] wdata,
    // settings of neighbouring registers
    input wire logic [7:0] raise_limit,
    input wire logic [1:0] decay_rate,
    // register readback and state
    output logic [7:0] alarm_clear_limit_set2,
    output logic [7:0] bucket_max_fill_set2,
    output logic [7:0] bucket_level,
    output logic inactivity_alarm,
    output logic cycle_tick
);

    logic [31:0] tick_cnt;
    logic fault_seen;
    logic [2:0] clean_run;
    logic [2:0] run_last;
    logic next_fault;

    ////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_clear_limit_set2 <= lbam_pkg::CLEAR_LIMIT_RESET;
            bucket_max_fill_set2 <= lbam_pkg::MAX_FILL_RESET;
        end else begin
            if (clear_limit_we) begin
                alarm_clear_limit_set2 <= wdata;
            end
            if (max_fill_we) begin
                bucket_max_fill_set2 <= wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // 128 ms cycle divider
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 32'h0;
            cycle_tick <= 1'b0;
        end else if (tick_cnt == 32'(CYCLE_CLKS - 1)) begin
            tick_cnt <= 32'h0;
            cycle_tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
            cycle_tick <= 1'b0;
        end
    end

    // fault latched over the cycle; the last clock of the cycle counts too
    assign next_fault = fault_seen | input_fault;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_seen <= 1'b0;
        end else if (cycle_tick) begin
            fault_seen <= input_fault;
        end else begin
            fault_seen <= next_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // decay rate decode
    always_comb begin
        unique case (decay_rate)
            lbam_pkg::DECAY_EVERY_1: run_last = lbam_pkg::RUN_1;
            lbam_pkg::DECAY_EVERY_2: run_last = lbam_pkg::RUN_2;
            lbam_pkg::DECAY_EVERY_4: run_last = lbam_pkg::RUN_4;
            lbam_pkg::DECAY_EVERY_8: run_last = lbam_pkg::RUN_8;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // accumulator, evaluated on the cycle tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bucket_level <= 8'h00;
            clean_run <= 3'h0;
        end else if (cycle_tick) begin
            if (fault_seen) begin
                clean_run <= 3'h0;
                if (bucket_level < bucket_max_fill_set2) begin
                    bucket_level <= bucket_level + 8'h01;
                end else begin
                    bucket_level <= bucket_max_fill_set2;
                end
            end else if (clean_run >= run_last) begin
                clean_run <= 3'h0;
                if (bucket_level != 8'h00) begin
                    bucket_level <= bucket_level - 8'h01;
                end
            end else begin
                clean_run <= clean_run + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // inactivity alarm with hysteresis
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inactivity_alarm <= 1'b0;
        end else if (bucket_level >= raise_limit) begin
            inactivity_alarm <= 1'b1;
        end else if (bucket_level <= alarm_clear_limit_set2) begin
            inactivity_alarm <= 1'b0;
        end
    end

endmodule // lbam_monitor

/* tb/lbam_asserts.sv */
// assertions on the activity monitor ports
`timescale 1ns/1ns
module lbam_asserts #(parameter int unsigned CYCLE_CLKS = 10) (
    input wire logic clk, rst_n, input_fault, clear_limit_we, max_fill_we, inactivity_alarm, cycle_tick,
    input wire logic [7:0] wdata, raise_limit, alarm_clear_limit_set2, bucket_max_fill_set2, bucket_level,
    input wire logic [1:0] decay_rate);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
sequence s_full; $past(cycle_tick) && $past(bucket_level) >= $past(bucket_max_fill_set2); endsequence
AST_HOLD: assert property (!$past(cycle_tick) |-> $stable(bucket_level)) else $error("level moved");
AST_TICK: assert property (cycle_tick |=> !cycle_tick) else $error("tick long");
AST_CAP: assert property (s_full |-> bucket_level <= $past(bucket_max_fill_set2)) else $error("over");
AST_FLOOR: assert property ($past(bucket_level) == 8'h00 |-> bucket_level != 8'hff) else $error("under");
AST_RAISE: assert property (bucket_level >= raise_limit |=> inactivity_alarm) else $error("no alarm");
AST_CLEAR: assert property (bucket_level <= alarm_clear_limit_set2 && bucket_level < raise_limit
    |=> !inactivity_alarm) else $error("alarm held");
AST_CLRREG: assert property (clear_limit_we |=> alarm_clear_limit_set2 == $past(wdata)) else $error("clr");
AST_MAXREG: assert property (max_fill_we |=> bucket_max_fill_set2 == $past(wdata)) else $error("max");
endmodule // lbam_asserts

/* tb/leaky_bucket_activity_monitor_test.sv */
// self-checking bench for the activity monitor
`timescale 1ns/1ns
module leaky_bucket_activity_monitor_test;
logic clk = 0, rst_n = 0, input_fault = 0, clear_limit_we = 0, max_fill_we = 0, inactivity_alarm, cycle_tick;
logic [7:0] wdata = 8'h00, raise_limit = 8'h03, alarm_clear_limit_set2, bucket_max_fill_set2, bucket_level;
logic [1:0] decay_rate = 2'h0;
int num_errors = 0, n_checks = 0;
lbam_monitor #(.CYCLE_CLKS(10)) i_dut (.*);
initial forever #50 clk = ~clk;
task chk(input string s, input logic [7:0] e, a);
    n_checks++;
    if (e !== a) begin
        num_errors++;
        $display("CHECK FAILED %s exp %h got %h", s, e, a);
    end
endtask
task finish_test;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
// wait n ticks, return one edge after the last
task t(input int n);
    repeat (n) begin
        @(negedge clk);
        while (!cycle_tick) @(negedge clk);
    end
    @(negedge clk);
endtask
task wr(input logic c, m, input logic [7:0] d);
    {clear_limit_we, max_fill_we, wdata} = {c, m, d};
    @(negedge clk);
    {clear_limit_we, max_fill_we} = 2'h0;
endtask
task sc_fill;
    wr(1'h1, 1'h0, 8'h01);
    wr(1'h0, 1'h1, 8'h03);
    input_fault = 1'h1;
    t(5);
    chk("lvl", 8'h03, bucket_level);
    @(negedge clk);
    chk("alarm", 8'h01, {7'h0, inactivity_alarm});
    input_fault = 0;
    t(3);
    chk("lvl", 8'h01, bucket_level);
    @(negedge clk);
    chk("alarm", 8'h00, {7'h0, inactivity_alarm});
    t(2);
    chk("lvl", 8'h00, bucket_level);
endtask
task sc_decay(input logic [1:0] r);
    decay_rate = r;
    input_fault = 1;
    @(negedge clk);
    input_fault = 0;
    t(1);
    t((1 << r) - 1);
    chk("lvl", 8'h01, bucket_level);
    t(1);
    chk("lvl", 8'h00, bucket_level);
endtask
initial begin
    #200 rst_n = 1;
    chk("clr", 8'h04, alarm_clear_limit_set2);
    chk("max", 8'h08, bucket_max_fill_set2);
    sc_fill;
    for (int r = 1; r < 4; r++) sc_decay(r[1:0]);
    finish_test;
end
initial begin
    #100000 num_errors++;
    finish_test;
end
endmodule // leaky_bucket_activity_monitor_test
bind lbam_monitor lbam_asserts #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (.*);
